/* File: tcs_pkg.sv */
package tcs_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] ADDR_CONTROL    = 8'h80;
	localparam logic [7:0] ADDR_STATUS     = 8'h81;
	localparam logic [7:0] ADDR_NODE_DELAY = 8'h8f;
	localparam logic [7:0] ADDR_SYNC_BW    = 8'h96;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h97;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL_MASTER   = 7;
	localparam int CTL_TX_EN    = 6;
	localparam int CTL_RSVD     = 5;
	localparam int CTL_WAKE     = 4;
	localparam int CTL_STANDA   = 3;
	localparam int CTL_SYNC_BYP = 2;
	localparam int CTL_PASS     = 1;
	localparam int CTL_RCLK_OFF = 0;
	localparam int ST_SPDIF_MSK = 6;
	localparam int ST_LINK_MSK  = 5;
	localparam int ST_CODE_MSK  = 4;
	localparam int ST_SUMMARY   = 3;
	localparam int ST_SPDIF_CAP = 1;
	localparam int ST_LINK_CAP  = 0;
	localparam int ST2_RX_FLIP  = 1;

	// ****************************************
	// Reset values and limits
	// ****************************************
	localparam logic [7:0] CONTROL_RESET   = 8'h20;
	localparam logic [2:0] MASK_RESET      = 3'h5;
	localparam logic [3:0] QUADLET_RESET   = 4'h0;
	localparam logic [3:0] QUADLET_MIN     = 4'h6;
	localparam logic [3:0] QUADLET_MAX     = 4'hf;
	localparam logic [7:0] BYTES_PER_QUAD  = 8'h04;
	localparam int         WAKE_PULSE_CYC  = 16;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tcs_bus_t;

	typedef struct packed {
		logic spdif_err;  // S/PDIF lock error level
		logic link_lock;  // Transceiver lock achieved / lost level
		logic code_err;   // Bi-phase or parity error level
	} tcs_events_t;

	// Byte channel number from quadlet index and byte offset
	function automatic logic [7:0] tcs_byte_number(input logic [3:0] quad, input logic [1:0] offs);
		tcs_byte_number = 8'({4'h0, quad} * BYTES_PER_QUAD) + {6'h00, offs};
	endfunction : tcs_byte_number
endpackage : tcs_pkg

/* File: tcs_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module tcs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_reset_n,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;  // Metastable stage, read only by stage2
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Shift chain
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Accept a value only when the two settled stages agree
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_sync <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					o_sync[i] <= stage3[i];
				end
			end
		end
	end
endmodule : tcs_sync

/* File: tcs_ctrl_status.sv */
`timescale 1ns/1ps
module tcs_ctrl_status
	import tcs_pkg::*;
#(
	parameter int WAKE_CYCLES = tcs_pkg::WAKE_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_reset_n,
	// Register access from the control port
	input  wire tcs_pkg::tcs_bus_t    i_bus,
	output logic [7:0]                o_rdata,
	// Stand-alone strap pins (read and write strobes)
	input  wire logic                 i_strap_rd,
	input  wire logic                 i_strap_wr,
	// Interrupt controls from elsewhere in the device
	input  wire logic                 i_fault_irq_enable,
	input  wire logic                 i_fault_irq_rearm,
	// Error events, asynchronous levels
	input  wire tcs_pkg::tcs_events_t i_events,
	// Network lock and frame-derived values
	input  wire logic                 i_net_lock,
	input  wire logic [3:0]           i_rx_quadlet_count,
	input  wire logic [7:0]           i_rx_node_delay,
	input  wire logic [7:0]           i_rx_node_position,
	// Network data path
	input  wire logic                 i_rx,
	input  wire logic                 i_node_tx,
	output logic                      o_tx,
	output logic                      o_rx_data,
	// Recovered clock pin
	input  wire logic                 i_recovered_clk,
	output logic                      o_rclk,
	output logic                      o_rclk_oe,
	// Node state towards the network engine
	output logic                      o_timing_master,
	output logic                      o_sync_delay_en,
	output logic                      o_active_member,
	output logic [7:0]                o_tx_node_delay,
	output logic [7:0]                o_tx_node_position,
	output logic [3:0]                o_quadlet_count,
	output logic                      o_quadlet_valid,
	output logic                      o_wakeup,
	// Error reporting
	output logic                      o_error_pin,
	output logic                      o_irq_n
);
	import tcs_pkg::*;

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0]  control;          // Stored control bits (wake bit unused, reads 0)
	logic        standalone;       // Strap captured after reset release
	logic        strap_taken;      // Strap capture done
	logic [2:0]  masks;            // {spdif, link, code}
	logic        summary;          // Sticky summary flag
	logic        spdif_cap;        // Sticky S/PDIF lock capture
	logic        link_cap;         // Sticky link lock capture
	logic        rx_flip;          // Receive polarity inversion
	logic [3:0]  quadlet_count;    // Synchronous quadlet count
	logic        irq_active;       // Interrupt currently asserted
	logic        irq_blocked;      // Held off until rearm
	logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt;  // Wake-up pulse timer
	tcs_events_t ev;               // Synchronised events
	logic        link_lock_d;      // Previous link lock level
	logic        link_event;       // Lock achieved or lost edge
	logic        unmasked;         // Any unmasked event this cycle
	logic        wr_ctl;
	logic        wr_st;
	logic        wr_sbc;
	logic        wr_st2;

	// ****************************************
	// Event synchroniser
	// ****************************************
	tcs_sync #(
		.WIDTH ($bits(tcs_events_t))
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_reset_n (i_reset_n),
		.i_async   (i_events),
		.o_sync    (ev)
	);

	// ****************************************
	// Register write decodes
	// ****************************************
	// One strobe cycle per access, so each decode is a single-cycle pulse;
	// writes to unmapped or read-only addresses simply fall through
	assign wr_ctl = i_bus.wr && (i_bus.addr == ADDR_CONTROL);
	assign wr_st  = i_bus.wr && (i_bus.addr == ADDR_STATUS);
	assign wr_sbc = i_bus.wr && (i_bus.addr == ADDR_SYNC_BW);
	assign wr_st2 = i_bus.wr && (i_bus.addr == ADDR_STATUS_TWO);

	// ****************************************
	// Control register
	// ****************************************
	// Resets to slave in full passthrough with reserved bit set
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			control <= CONTROL_RESET;
		end else if (wr_ctl) begin
			// Later bit assignments override the whole-byte copy
			control <= i_bus.wdata;
			// Reserved bit is forced so a careless write cannot clear it
			control[CTL_RSVD] <= 1'b1;
			control[CTL_WAKE] <= 1'b0;
		end
	end

	// Strap is sampled by a clocked process after release, never in reset.
	// The strobes are static straps here, so no synchroniser is used: the
	// board must hold them through the first edge after reset release.
	// A write to the stand-alone bit is ignored; the strap alone decides it.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			standalone  <= 1'b0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			standalone  <= !i_strap_rd && !i_strap_wr;
			strap_taken <= 1'b1;
		end
	end

	// Wake-up pulse only in a timing master: the node must already be master
	// and the same write must keep it so, otherwise a slave could wake the ring.
	// A second request during a pulse restarts the count.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wake_cnt <= '0;
		end else if (wr_ctl && i_bus.wdata[CTL_WAKE] && i_bus.wdata[CTL_MASTER] && control[CTL_MASTER]) begin
			wake_cnt <= ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES);
		end else if (wake_cnt != '0) begin
			wake_cnt <= wake_cnt - 1'b1;
		end
	end
	assign o_wakeup = (wake_cnt != '0);

	// ****************************************
	// Node role outputs
	// ****************************************
	assign o_timing_master = control[CTL_MASTER];
	assign o_active_member = control[CTL_PASS];
	assign o_sync_delay_en = !control[CTL_SYNC_BYP];

	// Delay and position handed on, registered.
	// A node in full passthrough cannot touch the stream, so it adds nothing
	// to either count even with synchronous bypass clear.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx_node_delay    <= 8'h00;
			o_tx_node_position <= 8'h00;
		end else begin
			// Master starts the chain at zero
			if (control[CTL_MASTER]) begin
				o_tx_node_delay <= 8'h00;
			end else if (!control[CTL_SYNC_BYP] && control[CTL_PASS]) begin
				o_tx_node_delay <= i_rx_node_delay + 8'h01;
			end else begin
				o_tx_node_delay <= i_rx_node_delay;
			end
			// Only active members are counted
			if (control[CTL_MASTER]) begin
				o_tx_node_position <= 8'h00;
			end else if (control[CTL_PASS]) begin
				o_tx_node_position <= i_rx_node_position + 8'h01;
			end else begin
				o_tx_node_position <= i_rx_node_position;
			end
		end
	end

	// ****************************************
	// Data path and recovered clock pin
	// ****************************************
	assign o_rx_data = i_rx ^ rx_flip;
	// Passthrough carries the raw line, inversion applies only inside the node
	assign o_tx = !control[CTL_PASS] ? i_rx : (control[CTL_TX_EN] & i_node_tx);
	// The divider that sets the pin's rate sits outside this block
	assign o_rclk    = i_recovered_clk;
	assign o_rclk_oe = !control[CTL_RCLK_OFF];

	// ****************************************
	// Error events
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			link_lock_d <= 1'b0;
		end else begin
			link_lock_d <= ev.link_lock;
		end
	end
	// Either edge of lock counts: gaining lock and losing it are both reported.
	// The delay stage resets to the idle level of the pin, so no false edge follows reset.
	assign link_event = ev.link_lock ^ link_lock_d;
	assign unmasked = (ev.spdif_err && !masks[2]) || (link_event && !masks[1])
		|| (ev.code_err && !masks[0]);
	// Pin follows the masked events with no memory; short events give short pulses
	assign o_error_pin = unmasked;

	// Masks
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			masks <= MASK_RESET;
		end else if (wr_st) begin
			masks <= i_bus.wdata[ST_SPDIF_MSK:ST_CODE_MSK];
		end
	end

	// Sticky flags: a new event wins over a software clear.
	// Writing 1 to a flag keeps it, so software can rewrite masks safely.
	// The captures ignore the masks so the cause stays visible.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			summary   <= 1'b0;
			spdif_cap <= 1'b0;
			link_cap  <= 1'b0;
		end else begin
			summary   <= unmasked || (summary && !(wr_st && !i_bus.wdata[ST_SUMMARY]));
			spdif_cap <= ev.spdif_err || (spdif_cap && !(wr_st && !i_bus.wdata[ST_SPDIF_CAP]));
			link_cap  <= link_event || (link_cap && !(wr_st && !i_bus.wdata[ST_LINK_CAP]));
		end
	end

	// ****************************************
	// Error interrupt
	// ****************************************
	// Rearm clears the line; one cycle later it rises again if cause remains
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_active  <= 1'b0;
			irq_blocked <= 1'b0;
		end else begin
			// Rearm wins over a new set in the same cycle; the set follows one edge later
			if (i_fault_irq_rearm) begin
				irq_active  <= 1'b0;
				irq_blocked <= 1'b0;
			end else if (!irq_blocked && summary && i_fault_irq_enable) begin
				irq_active  <= 1'b1;
				irq_blocked <= 1'b1;
			end
		end
	end
	assign o_irq_n = !irq_active;

	// ****************************************
	// Second status and bandwidth registers
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_flip <= 1'b0;
		end else if (wr_st2) begin
			rx_flip <= i_bus.wdata[ST2_RX_FLIP];
		end
	end

	// Master takes writes; slave follows incoming frames while locked.
	// Out of lock a slave keeps its last value rather than copying noise;
	// the valid flag below tells software not to trust it then.
	// A master write outside 6 to 15 is stored but never reported valid.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			quadlet_count <= QUADLET_RESET;
		end else if (control[CTL_MASTER]) begin
			if (wr_sbc) begin
				quadlet_count <= i_bus.wdata[3:0];
			end
		end else if (i_net_lock) begin
			quadlet_count <= i_rx_quadlet_count;
		end
	end
	assign o_quadlet_count = quadlet_count;
	assign o_quadlet_valid = i_net_lock && (quadlet_count >= QUADLET_MIN)
		&& (quadlet_count <= QUADLET_MAX);

	// ****************************************
	// Read data
	// ****************************************
	// Registered read data: valid the edge after the read strobe and held
	// until the next read, so a slow host can pick it up at leisure.
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			case (i_bus.addr)
				ADDR_CONTROL: begin
					o_rdata <= {control[7:5], 1'b0, standalone, control[2:0]};
				end
				ADDR_STATUS: begin
					o_rdata <= {1'b0, masks, summary, 1'b0, spdif_cap, link_cap};
				end
				ADDR_NODE_DELAY: begin
					o_rdata <= o_tx_node_delay;
				end
				ADDR_SYNC_BW: begin
					o_rdata <= {4'h0, quadlet_count};
				end
				ADDR_STATUS_TWO: begin
					o_rdata <= {6'h00, rx_flip, 1'b0};
				end
				default: begin
					o_rdata <= 8'h00;
				end
			endcase
		end
	end
endmodule : tcs_ctrl_status

/* File: tcs_props.sv */
`timescale 1ns/1ps
module tcs_props
	import tcs_pkg::*;
(
	// Clock and reset
	input wire logic              i_clk_sys,
	input wire logic              i_reset_n,
	// Inputs watched
	input wire tcs_pkg::tcs_bus_t i_bus,
	input wire logic              i_fault_irq_enable,
	input wire logic              i_fault_irq_rearm,
	input wire logic              i_net_lock,
	input wire logic [7:0]        i_rx_node_delay,
	input wire logic [7:0]        i_rx_node_position,
	input wire logic              i_rx,
	input wire logic              i_recovered_clk,
	// Outputs watched
	input wire logic [7:0]        o_rdata,
	input wire logic              o_tx,
	input wire logic              o_rclk,
	input wire logic              o_rclk_oe,
	input wire logic              o_timing_master,
	input wire logic              o_sync_delay_en,
	input wire logic              o_active_member,
	input wire logic [7:0]        o_tx_node_delay,
	input wire logic [7:0]        o_tx_node_position,
	input wire logic [3:0]        o_quadlet_count,
	input wire logic              o_quadlet_valid,
	input wire logic              o_wakeup,
	input wire logic              o_irq_n
);
	// One clock domain, so one default clocking and reset
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	// ****************************************
	// Data path and role
	// ****************************************
	a_bypass_tx_path: assert property (!o_active_member |-> o_tx == i_rx)
		else $error("tx not following rx in bypass");
	a_rclk_pin_drive: assert property (o_rclk_oe |-> o_rclk == i_recovered_clk)
		else $error("recovered clock pin wrong");
	a_master_by_write: assert property ($changed(o_timing_master)
		|-> $past(i_bus.wr && i_bus.addr == ADDR_CONTROL))
		else $error("master role changed without write");
	a_wake_master_only: assert property ($rose(o_wakeup) |-> o_timing_master
		&& $past(i_bus.wr && i_bus.addr == ADDR_CONTROL && i_bus.wdata[CTL_WAKE]))
		else $error("wake pulse without master write");
	a_control_readback: assert property (i_bus.rd && i_bus.addr == ADDR_CONTROL
		|=> o_rdata[CTL_RSVD] && !o_rdata[CTL_WAKE] && o_rdata[CTL_MASTER] == o_timing_master)
		else $error("control read back wrong");
	a_quad_valid_lock: assert property (o_quadlet_valid == (i_net_lock && o_quadlet_count >= QUADLET_MIN))
		else $error("quadlet valid wrong");
	// Passed-on counts need one settled cycle of the same role
	a_delay_master_zero: assert property (o_timing_master && $past(o_timing_master)
		|-> o_tx_node_delay == 8'h00)
		else $error("node delay not zero in master");
	// A node in full passthrough leaves the stream untouched, so only an active node adds one
	a_delay_slave_step: assert property ($past(i_reset_n)
		&& !o_timing_master && !$past(o_timing_master)
		|-> o_tx_node_delay == 8'($past(i_rx_node_delay)
		+ 8'($past(o_sync_delay_en) && $past(o_active_member))))
		else $error("node delay step wrong");
	a_position_step: assert property ($past(i_reset_n)
		&& !o_timing_master && !$past(o_timing_master)
		|-> o_tx_node_position == 8'($past(i_rx_node_position) + $past(o_active_member)))
		else $error("node position step wrong");

	// ****************************************
	// Interrupt
	// ****************************************
	a_irq_needs_enable: assert property ($fell(o_irq_n) |-> $past(i_fault_irq_enable))
		else $error("interrupt without enable");
	a_rearm_clears: assert property (i_fault_irq_rearm |=> o_irq_n)
		else $error("rearm did not clear interrupt");
endmodule : tcs_props

bind tcs_ctrl_status tcs_props u_props (
	.i_clk_sys, .i_reset_n, .i_bus, .i_fault_irq_enable, .i_fault_irq_rearm, .i_net_lock,
	.i_rx_node_delay, .i_rx_node_position, .i_rx, .i_recovered_clk, .o_rdata, .o_tx, .o_rclk,
	.o_rclk_oe, .o_timing_master, .o_sync_delay_en, .o_active_member, .o_tx_node_delay,
	.o_tx_node_position, .o_quadlet_count, .o_quadlet_valid, .o_wakeup, .o_irq_n
);

/* File: tcs_ring_model.sv */
`timescale 1ns/1ps
// Upstream ring neighbour: line data, recovered clock, lock and frame values
module tcs_ring_model (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_reset_n,
	// Towards the transceiver
	output logic       o_rx,
	output logic       o_rclk,
	output logic       o_lock,
	output logic [3:0] o_quadlets,
	output logic [7:0] o_delay,
	output logic [7:0] o_position
);
	logic [3:0] lock_cnt; // Cycles since reset, lock when full

	// Known values before the first reset edge
	initial begin
		lock_cnt = 4'h0;
		o_rx = 1'b0;
		o_rclk = 1'b0;
		o_quadlets = 4'h6;
		o_delay = 8'h00;
		o_position = 8'h00;
	end

	// Line toggles at random so a stale value cannot pass for a match
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lock_cnt <= 4'h0;
			o_rclk <= 1'b0;
		end else begin
			o_rclk <= !o_rclk;
			o_rx <= 1'($urandom);
			if (lock_cnt != 4'hf) begin
				lock_cnt <= lock_cnt + 4'h1;
			end
			// Frame values fixed once lock is reached
			if (lock_cnt == 4'he) begin
				o_quadlets <= 4'($urandom_range(15, 6));
				o_delay <= 8'($urandom_range(200));
				o_position <= 8'($urandom_range(60));
			end
		end
	end

	assign o_lock = (lock_cnt == 4'hf);
endmodule : tcs_ring_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import tcs_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic        i_clk_sys = 1'b0, i_reset_n = 1'b0, i_strap_rd = 1'b1, i_strap_wr = 1'b1;
	logic        i_fault_irq_enable = 1'b0, i_fault_irq_rearm = 1'b0, i_node_tx = 1'b0;
	tcs_bus_t    i_bus = '0;
	tcs_events_t i_events = '0;
	logic        i_rx, i_recovered_clk, i_net_lock;
	logic [3:0]  i_rx_quadlet_count, o_quadlet_count;
	logic [7:0]  i_rx_node_delay, i_rx_node_position, o_rdata, o_tx_node_delay, o_tx_node_position;
	logic        o_tx, o_rx_data, o_rclk, o_rclk_oe, o_timing_master, o_sync_delay_en, o_active_member;
	logic        o_quadlet_valid, o_wakeup, o_error_pin, o_irq_n;
	logic [7:0]  rd_q, q;
	int          error_cnt = 0, num_checks = 0, n;
	localparam int WAKE = 2; // Short wake pulse keeps the run brief
	logic [7:0]  ctl_tab[6] = '{8'ha2, 8'he2, 8'h20, 8'h25, 8'he6, 8'h63};

	always #50 i_clk_sys = !i_clk_sys;

	tcs_ring_model u_ring (.i_clk_sys, .i_reset_n, .o_rx(i_rx), .o_rclk(i_recovered_clk), .o_lock(i_net_lock),
		.o_quadlets(i_rx_quadlet_count), .o_delay(i_rx_node_delay), .o_position(i_rx_node_position));
	tcs_ctrl_status #(.WAKE_CYCLES(WAKE)) u_dut (.i_clk_sys, .i_reset_n, .i_bus, .o_rdata, .i_strap_rd,
		.i_strap_wr, .i_fault_irq_enable, .i_fault_irq_rearm, .i_events, .i_net_lock, .i_rx_quadlet_count,
		.i_rx_node_delay, .i_rx_node_position, .i_rx, .i_node_tx, .o_tx, .o_rx_data, .i_recovered_clk,
		.o_rclk, .o_rclk_oe, .o_timing_master, .o_sync_delay_en, .o_active_member, .o_tx_node_delay,
		.o_tx_node_position, .o_quadlet_count, .o_quadlet_valid, .o_wakeup, .o_error_pin, .o_irq_n);

	// ****************************************
	// Tasks and expectations
	// ****************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic end_sim;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim

	// One strobe cycle, then idle, so a strobe never lasts two edges
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_bus <= '{w, !w, a, d};
		@(posedge i_clk_sys);
		i_bus <= '0;
		#1 rd_q = o_rdata;
	endtask : acc

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(nm, e, rd_q);
	endtask : rdc

	// Strap level s on both strobes, held past the first edge after release
	task automatic rst(input logic s);
		i_reset_n <= 1'b0;
		i_strap_rd <= s;
		i_strap_wr <= s;
		repeat (10) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_strap_rd <= 1'b1;
		i_strap_wr <= 1'b1;
		#1;
	endtask : rst

	task automatic ev(input tcs_events_t e);
		@(posedge i_clk_sys);
		i_events <= e;
		repeat (8) @(posedge i_clk_sys);
		#1;
	endtask : ev

	task automatic rearm;
		@(posedge i_clk_sys);
		i_fault_irq_rearm <= 1'b1;
		@(posedge i_clk_sys);
		i_fault_irq_rearm <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		#1;
	endtask : rearm

	// Control read-back: wake reads 0, reserved 1, stand-alone from strap
	function automatic logic [7:0] exp_ctl(input logic [7:0] c, input logic s);
		return (c & 8'he7) | 8'h20 | {4'h0, s, 3'h0};
	endfunction : exp_ctl

	function automatic logic exp_tx(input logic [7:0] c, input logic rx, input logic ntx);
		return c[CTL_PASS] ? (c[CTL_TX_EN] & ntx) : rx;
	endfunction : exp_tx

	task automatic ctl_case(input logic [7:0] c);
		acc(1'b1, ADDR_CONTROL, c);
		chk("master", 8'(c[CTL_MASTER]), 8'(o_timing_master));
		chk("rclk oe", 8'(!c[CTL_RCLK_OFF]), 8'(o_rclk_oe));
		chk("sync delay", 8'(!c[CTL_SYNC_BYP]), 8'(o_sync_delay_en));
		chk("active", 8'(c[CTL_PASS]), 8'(o_active_member));
		for (int k = 0; k < 8; k++) begin
			@(posedge i_clk_sys);
			i_node_tx <= 1'($urandom);
			#1 chk("tx", 8'(exp_tx(c, i_rx, i_node_tx)), 8'(o_tx));
		end
		rdc("control", ADDR_CONTROL, exp_ctl(c, 1'b0));
	endtask : ctl_case

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		n = $urandom(44);
		rst(1'b1);
		chk("tx at reset", 8'(i_rx), 8'(o_tx));
		rdc("control", ADDR_CONTROL, CONTROL_RESET);
		rdc("status", ADDR_STATUS, 8'h50);
		rdc("status two", ADDR_STATUS_TWO, 8'h00);
		rdc("unmapped", 8'h55, 8'h00);
		repeat (12) @(posedge i_clk_sys);
		acc(1'b1, ADDR_SYNC_BW, 8'h03);
		rdc("slave quadlets", ADDR_SYNC_BW, {4'h0, i_rx_quadlet_count});
		acc(1'b1, ADDR_STATUS_TWO, 8'h02);
		chk("rx flip", 8'(!i_rx), 8'(o_rx_data));
		acc(1'b1, ADDR_STATUS_TWO, 8'h00);
		chk("rx plain", 8'(i_rx), 8'(o_rx_data));
		foreach (ctl_tab[i]) ctl_case(ctl_tab[i]);
		ctl_case(8'he2);
		for (int k = 0; k < 3; k++) begin
			q = (k == 0) ? 8'h06 : (k == 1) ? 8'h0f : 8'($urandom_range(15, 6));
			acc(1'b1, ADDR_SYNC_BW, q);
			rdc("master quadlets", ADDR_SYNC_BW, q);
			chk("quadlet valid", 8'(i_net_lock), 8'(o_quadlet_valid));
		end
		rdc("master delay", ADDR_NODE_DELAY, 8'h00);
		chk("byte number", 8'h3b, tcs_byte_number(4'he, 2'h3));
		acc(1'b1, ADDR_CONTROL, 8'hf2);
		n = int'(o_wakeup === 1'b1);
		for (int k = 0; k < 40; k++) begin
			@(posedge i_clk_sys);
			#1 n += int'(o_wakeup === 1'b1);
		end
		chk("wake length", 8'(WAKE), 8'(n));
		rdc("wake reads 0", ADDR_CONTROL, 8'he2);
		acc(1'b1, ADDR_CONTROL, 8'h32);
		repeat (4) @(posedge i_clk_sys);
		#1 chk("slave wake", 8'h00, 8'(o_wakeup));
		ev('{1'b0, 1'b0, 1'b1});
		chk("error pin masked", 8'h00, 8'(o_error_pin));
		ev('0);
		rdc("coding masked", ADDR_STATUS, 8'h50);
		acc(1'b1, ADDR_STATUS, 8'h40);
		ev('{1'b0, 1'b0, 1'b1});
		chk("error pin on", 8'h01, 8'(o_error_pin));
		ev('0);
		chk("error pin off", 8'h00, 8'(o_error_pin));
		rdc("coding summary", ADDR_STATUS, 8'h48);
		chk("irq disabled", 8'h01, 8'(o_irq_n));
		acc(1'b1, ADDR_STATUS, 8'h50);
		@(posedge i_clk_sys);
		i_fault_irq_enable <= 1'b1;
		ev('{1'b0, 1'b1, 1'b0});
		rdc("lock capture", ADDR_STATUS, 8'h59);
		chk("irq low", 8'h00, 8'(o_irq_n));
		rearm();
		chk("irq again", 8'h00, 8'(o_irq_n));
		acc(1'b1, ADDR_STATUS, 8'h50);
		rdc("cleared", ADDR_STATUS, 8'h50);
		rearm();
		chk("irq released", 8'h01, 8'(o_irq_n));
		rst(1'b0);
		rdc("stand-alone", ADDR_CONTROL, exp_ctl(CONTROL_RESET, 1'b1));
		end_sim();
	end

	// Guard against a hang anywhere above
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		error_cnt++;
		end_sim();
	end
endmodule : tb_top
